// ### src/rmc_reset_mode_clock_select.sv
// Reset pin sequencer, mode strap, debug pin and clock source selection
`include "rmc_defs.svh"
`default_nettype none

module rmc_reset_mode_clock_select (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Reset pin, open-drain
   input wire logic rstPinIn,
   output logic rstPinOut,
   output logic rstPinOeN,
   // Internal reset events, one-cycle pulses
   input wire logic lvdEvent,
   input wire logic copEvent,
   input wire logic ilopEvent,
   input wire logic iladEvent,
   input wire logic dbgRstEvent,
   // Reset status
   output logic chipReset,
   output logic [7:0] resetCauseStatus,
   output logic resetPinStuck,
   output rmc_pkg::rmc_state_e seqState,
   output logic backgroundMode,
   // Shared debug pin
   input wire logic debugPinIn,
   output logic debugPinOut,
   output logic debugPinOeN,
   input wire logic portMode,
   input wire logic portData,
   input wire logic dbgDriveLow,
   input wire logic dbgSpeedup,
   input wire logic dbgClkSelf,
   output logic dbgBitTick,
   // Clock source ticks, same clock domain
   input wire logic crystalTick,
   input wire logic extClkTick,
   input wire logic dcoTick,
   input wire logic refTick,
   // Clock control
   input wire logic [1:0] genSourceSel,
   input wire logic rtiRefSel,
   input wire logic stopRecovery,
   input wire logic stopRecSelfEn,
   input wire logic rangeSelect,
   input wire logic extOscMode,
   input wire logic crystalOutData,
   // Clock results
   output logic clockgenTick,
   output logic busTick,
   output logic fixedFreqSelect,
   output logic fixedFreqTick,
   output logic rtiTick,
   output logic useSelfClock,
   output logic oscRangeHigh,
   output logic crystalOutIsGpio,
   output logic crystalOutPin
);
   import rmc_pkg::*;

   // ==========================================================
   // Reset values
   localparam rmc_state_s RESET_STATE = '{
      st: RMC_DRIVE,
      cnt: 6'h00,
      cause: `RMC_CAUSE_RESET_VALUE,
      rstSync: 2'h0,
      dbgSync: 2'h3,
      acc: 14'h0000,
      selfTick: 1'b0,
      chipReset: 1'b1,
      pinStuck: 1'b0,
      rstPinOeN: 1'b0,
      bgMode: 1'b0,
      genCnt: 3'h0,
      ffe: 1'b0,
      ffTick: 1'b0,
      genTick: 1'b0,
      busTick: 1'b0,
      rtiTick: 1'b0,
      bitCnt: 4'h0,
      dbgBitTick: 1'b0,
      dbgPinOut: 1'b0,
      dbgPinOeN: 1'b1,
      xtalGpio: 1'b0,
      xtalOut: 1'b0,
      rangeHigh: 1'b0,
      useSelf: 1'b1
   };

   localparam logic [13:0] SELF_STEP = 14'(`RMC_SELF_CLK_KHZ);
   localparam logic [13:0] SYS_WRAP = 14'(`RMC_SYS_CLK_KHZ);
   localparam logic [5:0] LOW_LAST = 6'(`RMC_PIN_LOW_TICKS - 1);
   localparam logic [5:0] WAIT_LAST = 6'(`RMC_SAMPLE_WAIT_TICKS - 1);
   localparam logic [3:0] BIT_LAST = 4'(`RMC_DBG_BIT_CYCLES - 1);
   localparam logic [2:0] FFE_LIMIT = 3'(`RMC_FFE_RATIO);

   rmc_state_s q;
   rmc_state_s d;
   logic [7:0] newCause;
   logic anyInternal;
   logic pinLow;
   logic genNow;
   logic dbgTickSrc;

   always_comb begin
      d = q;

      // ==========================================================
      // Pin synchronisers
      d.rstSync = {q.rstSync[0], rstPinIn};
      d.dbgSync = {q.dbgSync[0], debugPinIn};
      pinLow = ~q.rstSync[1];

      // ==========================================================
      // Self-reset clock as a fractional enable, close to 8 MHz
      d.selfTick = 1'b0;
      if (q.acc + SELF_STEP >= SYS_WRAP) begin
         d.acc = q.acc + SELF_STEP - SYS_WRAP;
         d.selfTick = 1'b1;
      end else begin
         d.acc = q.acc + SELF_STEP;
      end

      // ==========================================================
      // Reset sequencer
      newCause = 8'h00;
      newCause[`RMC_CAUSE_LVD] = lvdEvent;
      newCause[`RMC_CAUSE_COP] = copEvent;
      newCause[`RMC_CAUSE_ILOP] = ilopEvent;
      newCause[`RMC_CAUSE_ILAD] = iladEvent;
      newCause[`RMC_CAUSE_DBG] = dbgRstEvent;
      anyInternal = |newCause;
      unique case (q.st)
         RMC_RUN: begin
            if (anyInternal) begin
               d.st = RMC_DRIVE;
               d.cause = newCause;
               d.cnt = 6'h00;
               d.chipReset = 1'b1;
               d.rstPinOeN = 1'b0;
            end else if (pinLow) begin
               d.st = RMC_DRIVE;
               d.cause = 8'h00;
               d.cause[`RMC_CAUSE_PIN] = 1'b1;
               d.cnt = 6'h00;
               d.chipReset = 1'b1;
               d.rstPinOeN = 1'b0;
            end
         end
         RMC_DRIVE: begin
            d.cause = q.cause | newCause;
            if (q.selfTick) begin
               if (q.cnt == LOW_LAST) begin
                  d.st = RMC_WAIT;
                  d.rstPinOeN = 1'b1;
                  d.cnt = 6'h00;
               end else begin
                  d.cnt = q.cnt + 6'h01;
               end
            end
         end
         RMC_WAIT: begin
            d.cause = q.cause | newCause;
            if (q.selfTick) begin
               if (q.cnt == WAIT_LAST) begin
                  // Released pin should read high unless held outside
                  if (pinLow) begin
                     d.st = RMC_HOLD;
                     d.pinStuck = 1'b1;
                     d.cause[`RMC_CAUSE_PIN] = 1'b1;
                  end else begin
                     d.st = RMC_RUN;
                     d.chipReset = 1'b0;
                     d.pinStuck = 1'b0;
                     d.bgMode = ~q.dbgSync[1];
                  end
               end else begin
                  d.cnt = q.cnt + 6'h01;
               end
            end
         end
         RMC_HOLD: begin
            d.cause = q.cause | newCause;
            if (!pinLow) begin
               d.st = RMC_RUN;
               d.chipReset = 1'b0;
               d.pinStuck = 1'b0;
               d.bgMode = ~q.dbgSync[1];
            end
         end
      endcase

      // ==========================================================
      // Shared debug pin
      if (q.chipReset) begin
         // Released so the strap can be read
         d.dbgPinOeN = 1'b1;
         d.dbgPinOut = 1'b0;
      end else if (portMode) begin
         d.dbgPinOeN = 1'b0;
         d.dbgPinOut = portData;
      end else if (dbgDriveLow) begin
         d.dbgPinOeN = 1'b0;
         d.dbgPinOut = 1'b0;
      end else if (dbgSpeedup) begin
         // Driven high for each cycle dbgSpeedup is set, for a fast rising edge
         d.dbgPinOeN = 1'b0;
         d.dbgPinOut = 1'b1;
      end else begin
         d.dbgPinOeN = 1'b1;
         d.dbgPinOut = 1'b0;
      end

      // ==========================================================
      // Clock generator output source
      unique case (genSourceSel)
         `RMC_SRC_CRYSTAL: genNow = crystalTick;
         `RMC_SRC_EXTERNAL: genNow = extClkTick;
         `RMC_SRC_DCO: genNow = dcoTick;
         default: genNow = dcoTick;
      endcase
      d.genTick = genNow;

      // Self clock in reset, and for stop recovery when enabled
      d.useSelf = q.chipReset | (stopRecovery & stopRecSelfEn);
      d.busTick = q.useSelf ? q.selfTick : q.genTick;

      // ==========================================================
      // Fixed-frequency select: count output edges per reference edge
      if (refTick) begin
         d.genCnt = {2'h0, genNow};
         d.ffe = (q.genCnt > FFE_LIMIT);
      end else if (genNow && q.genCnt != 3'h7) begin
         d.genCnt = q.genCnt + 3'h1;
      end
      // Decision only moves on a reference edge and the output is a
      // registered whole pulse, so no partial pulse can appear
      d.ffTick = q.ffe ? refTick : q.busTick;

      d.rtiTick = rtiRefSel ? refTick : q.selfTick;

      // ==========================================================
      // Debug controller clock and bit timing
      dbgTickSrc = dbgClkSelf ? q.selfTick : q.busTick;
      d.dbgBitTick = 1'b0;
      if (q.chipReset) begin
         d.bitCnt = 4'h0;
      end else if (dbgTickSrc) begin
         if (q.bitCnt == BIT_LAST) begin
            d.bitCnt = 4'h0;
            d.dbgBitTick = 1'b1;
         end else begin
            d.bitCnt = q.bitCnt + 4'h1;
         end
      end

      // ==========================================================
      // Oscillator pins
      d.rangeHigh = rangeSelect;
      d.xtalGpio = extOscMode;
      d.xtalOut = extOscMode ? crystalOutData : 1'b0;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         q <= RESET_STATE;
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // Outputs, all straight from the state register except rstPinOut, which is tied low
   assign rstPinOut = 1'b0;
   assign rstPinOeN = q.rstPinOeN;
   assign chipReset = q.chipReset;
   assign resetCauseStatus = q.cause;
   assign resetPinStuck = q.pinStuck;
   assign seqState = q.st;
   assign backgroundMode = q.bgMode;
   assign debugPinOut = q.dbgPinOut;
   assign debugPinOeN = q.dbgPinOeN;
   assign dbgBitTick = q.dbgBitTick;
   assign clockgenTick = q.genTick;
   assign busTick = q.busTick;
   assign fixedFreqSelect = q.ffe;
   assign fixedFreqTick = q.ffTick;
   assign rtiTick = q.rtiTick;
   assign useSelfClock = q.useSelf;
   assign oscRangeHigh = q.rangeHigh;
   assign crystalOutIsGpio = q.xtalGpio;
   assign crystalOutPin = q.xtalOut;

endmodule // rmc_reset_mode_clock_select
`default_nettype wire

// ### src/rmc_defs.svh
// Constants for the reset, mode and clock select block
`ifndef RMC_DEFS_SVH
`define RMC_DEFS_SVH

// ==========================================================
// Clock rates
`define RMC_SYS_CLK_KHZ 10000
`define RMC_SELF_CLK_KHZ 8000

// ==========================================================
// Reset pin sequence, in self-reset clock cycles
`define RMC_PIN_LOW_TICKS 34
`define RMC_SAMPLE_WAIT_TICKS 38

// ==========================================================
// Debug link and fixed-frequency decision
`define RMC_DBG_BIT_CYCLES 16
`define RMC_FFE_RATIO 4

// ==========================================================
// Reset cause bit positions
`define RMC_CAUSE_POR 7
`define RMC_CAUSE_PIN 6
`define RMC_CAUSE_COP 5
`define RMC_CAUSE_ILOP 4
`define RMC_CAUSE_ILAD 3
`define RMC_CAUSE_DBG 2
`define RMC_CAUSE_LVD 1
`define RMC_CAUSE_RESET_VALUE 8'h80

// ==========================================================
// Clock generator source codes
`define RMC_SRC_CRYSTAL 2'h0
`define RMC_SRC_EXTERNAL 2'h1
`define RMC_SRC_DCO 2'h2

`endif

// ### src/rmc_pkg.sv
// Types for the reset, mode and clock select block
`default_nettype none
package rmc_pkg;

   typedef enum logic [1:0] {
      RMC_RUN = 2'b00,
      RMC_DRIVE = 2'b01,
      RMC_WAIT = 2'b10,
      RMC_HOLD = 2'b11
   } rmc_state_e;

   typedef struct packed {
      rmc_state_e st;
      logic [5:0] cnt;
      logic [7:0] cause;
      logic [1:0] rstSync;
      logic [1:0] dbgSync;
      logic [13:0] acc;
      logic selfTick;
      logic chipReset;
      logic pinStuck;
      logic rstPinOeN;
      logic bgMode;
      logic [2:0] genCnt;
      logic ffe;
      logic ffTick;
      logic genTick;
      logic busTick;
      logic rtiTick;
      logic [3:0] bitCnt;
      logic dbgBitTick;
      logic dbgPinOut;
      logic dbgPinOeN;
      logic xtalGpio;
      logic xtalOut;
      logic rangeHigh;
      logic useSelf;
   } rmc_state_s;

endpackage
`default_nettype wire

// ### verif/rmc_seq_props.sv
// Checker for the reset, mode and clock select block
`default_nettype none
module rmc_seq_props (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Reset sequence
   input wire logic rstPinOeN,
   input wire logic copEvent,
   input wire logic chipReset,
   input wire logic [7:0] resetCauseStatus,
   input wire rmc_pkg::rmc_state_e seqState,
   input wire logic backgroundMode,
   // Debug pin and fixed clock
   input wire logic debugPinIn,
   input wire logic debugPinOut,
   input wire logic debugPinOeN,
   input wire logic portMode,
   input wire logic portData,
   input wire logic dbgSpeedup,
   input wire logic refTick,
   input wire logic fixedFreqSelect
);
   timeunit 1ns;
   timeprecision 1ns;
   import rmc_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // ====
   // Cycle counters: 4 self ticks per 5 cycles, so 34 -> ~43, 38 -> ~48
   logic [6:0] lowCnt_q;
   logic [6:0] waitCnt_q;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         lowCnt_q <= 7'h00;
         waitCnt_q <= 7'h00;
      end else begin
         lowCnt_q <= rstPinOeN ? 7'h00 : lowCnt_q + 7'h01;
         waitCnt_q <= (seqState == RMC_WAIT) ? waitCnt_q + 7'h01 : 7'h00;
      end
   end
   // ====
   // Strap is judged before the release edge; the pod lets go just after
   sequence strapLow_s;
      (!debugPinIn)[*5] ##1 $fell(chipReset);
   endsequence
   sequence strapHigh_s;
      debugPinIn[*5] ##1 $fell(chipReset);
   endsequence
   drive_len_a: assert property (
      $rose(rstPinOeN) |-> lowCnt_q inside {[7'h29:7'h2D]}) else $error("drive");
   drive_in_reset_a: assert property (
      !rstPinOeN |-> chipReset) else $error("drive out of reset");
   sample_wait_a: assert property (
      $fell(seqState == RMC_WAIT) |-> waitCnt_q inside {[7'h2D:7'h32]})
      else $error("wait");
   cop_cause_a: assert property (
      copEvent && seqState == RMC_RUN |=> chipReset && !rstPinOeN
      && resetCauseStatus == 8'h20) else $error("cop cause");
   dbg_released_a: assert property (
      chipReset && $past(chipReset) |-> debugPinOeN) else $error("dbg drive");
   strap_bg_a: assert property (
      strapLow_s |-> backgroundMode) else $error("strap low");
   strap_norm_a: assert property (
      strapHigh_s |-> !backgroundMode) else $error("strap high");
   port_out_a: assert property (
      portMode && !chipReset |=> chipReset
      || (!debugPinOeN && debugPinOut == $past(portData))) else $error("port");
   open_drain_a: assert property (
      !debugPinOeN && !$past(portMode) && !$past(dbgSpeedup) |-> !debugPinOut)
      else $error("high drive");
   ff_at_ref_a: assert property (
      $changed(fixedFreqSelect) |-> $past(refTick)) else $error("ff switch");
endmodule // rmc_seq_props
`default_nettype wire

// ### verif/rmc_pod_model.sv
// Reset switch and debug pod on the far side of the pins
`default_nettype none
module rmc_pod_model (
   // Bench commands
   input wire logic pullReset,
   input wire logic holdModeLow,
   // Device drivers
   input wire logic rstPinOut,
   input wire logic rstPinOeN,
   input wire logic debugPinOut,
   input wire logic debugPinOeN,
   // Resolved levels, pull-up on both
   output logic rstPinIn,
   output logic debugPinIn
);
   timeunit 1ns;
   timeprecision 1ns;
   assign rstPinIn = (pullReset || (!rstPinOeN && !rstPinOut)) ? 1'b0 : 1'b1;
   // Pod low wins over a device high pulse
   assign debugPinIn = holdModeLow ? 1'b0 : (debugPinOeN | debugPinOut);
endmodule // rmc_pod_model
`default_nettype wire

// ### verif/tb_reset_mode_clock_select.sv
// Self-checking bench for the reset, mode and clock select block
`include "rmc_defs.svh"
`default_nettype none
module tb_reset_mode_clock_select;
   timeunit 1ns;
   timeprecision 1ns;
   import rmc_pkg::*;
   logic clk_sys, rst, pullReset, holdModeLow, portMode, portData;
   logic dbgDriveLow, dbgSpeedup, dbgClkSelf, rtiRefSel, stopRecovery;
   logic stopRecSelfEn, rangeSelect, extOscMode, crystalOutData;
   logic [4:0] evt;
   logic [1:0] genSourceSel;
   logic [2:0] tickCnt = 3'h0;
   logic rstPinIn, rstPinOut, rstPinOeN, debugPinIn, debugPinOut, debugPinOeN;
   logic chipReset, resetPinStuck, backgroundMode, dbgBitTick, clockgenTick;
   logic busTick, fixedFreqSelect, fixedFreqTick, rtiTick, useSelfClock;
   logic oscRangeHigh, crystalOutIsGpio, crystalOutPin;
   logic [7:0] resetCauseStatus;
   rmc_state_e seqState;
   int nFail, numChecks, nGen, nRti, nFf, nGap, nBus;
   int pos[5] = '{`RMC_CAUSE_LVD, `RMC_CAUSE_COP, `RMC_CAUSE_ILOP,
      `RMC_CAUSE_ILAD, `RMC_CAUSE_DBG};
   int gexp[4] = '{10, 15, 35, 35};
   // ====
   // Sources repeat every 8 cycles: crystal 2, external 3, oscillator 7
   rmc_reset_mode_clock_select i_dut (.lvdEvent(evt[0]), .copEvent(evt[1]),
      .ilopEvent(evt[2]), .iladEvent(evt[3]), .dbgRstEvent(evt[4]),
      .crystalTick(tickCnt[1:0] == 2'h1),
      .extClkTick(tickCnt[0] && tickCnt != 3'h7),
      .dcoTick(tickCnt != 3'h0), .refTick(tickCnt == 3'h7), .*);
   rmc_pod_model i_pod (.*);
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   always @(negedge clk_sys) tickCnt <= tickCnt + 3'h1;
   // ====
   task automatic chk(string nm, logic [7:0] e, logic [7:0] v);
      numChecks++;
      if (v !== e) begin
         nFail++;
         $display("wrong value %s exp %h got %h", nm, e, v);
      end
   endtask
   task automatic waitRun();
      repeat (400) if (chipReset !== 1'b0) @(negedge clk_sys);
      chk("chipReset", 8'h00, 8'(chipReset));
   endtask
   // Cycles between two bit ticks
   task automatic bitGap();
      repeat (200) if (dbgBitTick !== 1'b1) @(negedge clk_sys);
      @(negedge clk_sys);
      nGap = 1;
      repeat (200) if (dbgBitTick !== 1'b1) begin
         nGap++;
         @(negedge clk_sys);
      end
   endtask
   task automatic tally_and_finish();
      if (nFail == 0 && numChecks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      #1_000_000;
      nFail++;
      tally_and_finish();
   end
   // ====
   initial begin
      rst = 1'b1;
      {pullReset, holdModeLow, portMode, portData, dbgDriveLow, dbgSpeedup,
         dbgClkSelf, rtiRefSel, stopRecovery, stopRecSelfEn, rangeSelect,
         extOscMode, crystalOutData, evt, genSourceSel} = '0;
      repeat (5) @(negedge clk_sys);
      chk("selfClk", 8'h01, 8'(useSelfClock));
      chk("pinOeN", 8'h00, 8'({rstPinOeN, rstPinOut, rstPinIn}));
      rst = 1'b0;
      waitRun();
      chk("cause", `RMC_CAUSE_RESET_VALUE, resetCauseStatus);
      chk("bgMode", 8'h00, 8'(backgroundMode));
      for (int i = 0; i < 5; i++) begin
         holdModeLow = i[0];
         evt = 5'h01 << i;
         @(negedge clk_sys);
         evt = 5'h00;
         chk("cause", 8'h01 << pos[i], resetCauseStatus);
         if (i == 1) begin
            evt = 5'h01;
            @(negedge clk_sys);
            evt = 5'h00;
            @(negedge clk_sys);
            chk("orCause", 8'h22, resetCauseStatus);
         end
         waitRun();
         chk("bgMode", 8'(i[0]), 8'(backgroundMode));
         holdModeLow = 1'b0;
      end
      pullReset = 1'b1;
      repeat (300) if (resetPinStuck !== 1'b1) @(negedge clk_sys);
      chk("stuck", 8'h01, 8'(resetPinStuck));
      chk("pinCause", 8'h40, resetCauseStatus);
      pullReset = 1'b0;
      waitRun();
      for (int d = 0; d < 2; d++) begin
         {portMode, portData} = {1'b1, d[0]};
         repeat (2) @(negedge clk_sys);
         chk("port", 8'(d[0]), 8'({debugPinOeN, debugPinOut}));
      end
      portMode = 1'b0;
      dbgSpeedup = 1'b1;
      @(negedge clk_sys);
      dbgSpeedup = 1'b0;
      chk("speedup", 8'h01, 8'({debugPinOeN, debugPinOut}));
      @(negedge clk_sys);
      chk("spdEnd", 8'h01, 8'(debugPinOeN));
      dbgDriveLow = 1'b1;
      @(negedge clk_sys);
      chk("drvLow", 8'h00, 8'({debugPinOeN, debugPinOut}));
      dbgDriveLow = 1'b0;
      rtiRefSel = 1'b1;
      for (int s = 0; s < 4; s++) begin
         genSourceSel = s[1:0];
         repeat (24) @(negedge clk_sys);
         {nGen, nRti, nFf, nBus} = '0;
         repeat (40) @(negedge clk_sys) begin
            nGen += clockgenTick;
            nBus += busTick;
            nRti += rtiTick;
            nFf += fixedFreqTick;
         end
         chk("gen", 8'(gexp[s]), 8'(nGen));
         chk("bus", 8'(gexp[s]), 8'(nBus));
         chk("rti", 8'h05, 8'(nRti));
         chk("ffSel", 8'(s[1]), 8'(fixedFreqSelect));
         chk("ffTick", 8'(s[1] ? 5 : gexp[s]), 8'(nFf));
      end
      genSourceSel = 2'h0;
      bitGap();
      chk("bitBus", 8'h40, 8'(nGap));
      dbgClkSelf = 1'b1;
      bitGap();
      bitGap();
      chk("bitSelf", 8'h14, 8'(nGap));
      {stopRecovery, stopRecSelfEn} = 2'h3;
      repeat (3) @(negedge clk_sys);
      chk("stopSelf", 8'h01, 8'(useSelfClock));
      {rangeSelect, extOscMode, crystalOutData} = 3'h7;
      repeat (2) @(negedge clk_sys);
      chk("crystal_out", 8'h07, 8'({oscRangeHigh, crystalOutIsGpio, crystalOutPin}));
      extOscMode = 1'b0;
      repeat (2) @(negedge clk_sys);
      chk("xtalOff", 8'h04, 8'({oscRangeHigh, crystalOutIsGpio, crystalOutPin}));
      tally_and_finish();
   end
endmodule // tb_reset_mode_clock_select
bind rmc_reset_mode_clock_select rmc_seq_props i_chk (.clk_sys(clk_sys),
   .rst(rst), .rstPinOeN(rstPinOeN), .copEvent(copEvent),
   .chipReset(chipReset), .resetCauseStatus(resetCauseStatus),
   .seqState(seqState), .backgroundMode(backgroundMode),
   .debugPinIn(debugPinIn), .debugPinOut(debugPinOut),
   .debugPinOeN(debugPinOeN), .portMode(portMode), .portData(portData),
   .dbgSpeedup(dbgSpeedup), .refTick(refTick),
   .fixedFreqSelect(fixedFreqSelect));
`default_nettype wire
